// file: rsf_pkg.sv
package rsf_pkg;

  localparam int unsigned CLK_HZ               = 125_000_000;
  localparam int unsigned CHECK_INTERVAL_HOURS = 24;
  localparam int unsigned SECONDS_PER_HOUR     = 3600;
  localparam longint unsigned CHECK_INTERVAL_CYCLES =
    longint'(CHECK_INTERVAL_HOURS) * longint'(SECONDS_PER_HOUR) * longint'(CLK_HZ);
  localparam int CHK_CNT_W  = 44;
  localparam int AHB_ADDR_W = 8;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TRIM  = 8'h08;
  localparam logic [7:0] OFS_TIMER = 8'h0c;
  localparam logic [7:0] OFS_WDOG  = 8'h10;
  localparam logic [7:0] OFS_RPT   = 8'h14;
  localparam logic [7:0] OFS_CENT  = 8'h18;
  localparam logic [7:0] OFS_ISTAT = 8'h1c;
  localparam logic [7:0] OFS_IMASK = 8'h20;

  localparam int B_STOP = 0;
  localparam int B_FT   = 1;
  localparam int B_SQUARE_WAVE_ENABLE = 2;
  localparam int B_ABE  = 3;
  localparam int B_OSC_FAIL_IRQ_ENABLE = 4;
  localparam int B_FIRST_ALARM_IRQ_ENABLE = 5;
  localparam int B_HT   = 6;
  localparam int B_OUT  = 7;
  localparam int B_PIN  = 8;
  localparam int B_OF   = 2;
  localparam int B_BL   = 4;
  localparam int B_DTV  = 0;
  localparam int B_DTS  = 6;
  localparam int B_ATV  = 8;
  localparam int B_ATS  = 16;
  localparam int B_TD   = 0;
  localparam int B_TIE  = 5;
  localparam int B_TP   = 6;
  localparam int B_TE   = 7;
  localparam int B_RS0  = 8;
  localparam int B_RSU  = 9;
  localparam int B_OTP  = 12;
  localparam int B_SECOND_ALARM_ENABLE = 13;
  localparam int B_RB   = 0;
  localparam int B_BMB  = 2;
  localparam int B_RPT1 = 0;
  localparam int B_RPT2 = 8;
  localparam int B_CB   = 0;
  localparam int B_LEAP = 2;

  localparam int IRQ_W  = 3;
  localparam int I_OF   = 0;
  localparam int I_BL   = 1;
  localparam int I_CENT = 2;

  typedef struct packed {
    logic [2:0]           oscSync;
    logic [2:0]           battSync;
    logic [2:0]           pwrSync;
    logic [2:0]           pinSync;
    logic                 oscStopped;
    logic                 battLow;
    logic                 pwrGood;
    logic                 pinLevel;
    logic [CHK_CNT_W-1:0] checkCnt;
    logic                 stopBit;
    logic                 freqTest;
    logic                 sqwEnable;
    logic                 backupAlarmEn;
    logic                 ofIrqEn;
    logic                 a1IrqEn;
    logic                 haltUpdate;
    logic                 outLevel;
    logic                 battLowFlag;
    logic                 oscFailFlag;
    logic [5:0]           digitalTrimValue;
    logic                 digitalTrimSign;
    logic [7:0]           analogTrimValue;
    logic                 analogTrimSign;
    logic                 countdownEnable;
    logic                 countdownPulseMode;
    logic                 countdownIrqEn;
    logic [1:0]           countdownSrcSel;
    logic                 rateSelBit0;
    logic [2:0]           rateSelUpper;
    logic                 otpBit;
    logic                 secondAlarmEnable;
    logic [4:0]           watchdogMult;
    logic [1:0]           watchdogRes;
    logic [4:0]           firstAlarmRepeat;
    logic [4:0]           secondAlarmRepeat;
    logic [IRQ_W-1:0]     irqStatus;
    logic [IRQ_W-1:0]     irqMask;
    logic                 irqPinOe;
    logic                 irqOut;
    logic                 busActive;
    logic                 busWrite;
    logic [AHB_ADDR_W-1:0] busAddr;
  } rsf_state_t;

  localparam rsf_state_t RESET_STATE = '{
    default:         '0,
    sqwEnable:       1'b1,
    outLevel:        1'b1,
    haltUpdate:      1'b1,
    oscFailFlag:     1'b1,
    countdownSrcSel: 2'h3,
    rateSelBit0:     1'b1
  };

  typedef struct packed {
    logic [1:0] century;
    logic       leapYear;
  } rsf_cent_state_t;

  localparam rsf_cent_state_t CENT_RESET_STATE = '{default: '0};

endpackage

// file: rsf_cent_if.sv
`timescale 1ns/1ns
interface rsf_cent_if;
  logic       yearRoll;
  logic [7:0] yearBcd;
  logic       wrEn;
  logic [1:0] wrData;
  logic [1:0] century;
  logic       leapYear;

  modport core (output yearRoll, yearBcd, wrEn, wrData, input century, leapYear);
  modport cent (input yearRoll, yearBcd, wrEn, wrData, output century, leapYear);
endinterface

// file: rsf_century.sv
`timescale 1ns/1ns
module rsf_century (
  input  wire logic clk_sys,
  input  wire logic rstSyncN,
  rsf_cent_if.cent  centIf
);

  rsf_pkg::rsf_cent_state_t s_q;
  rsf_pkg::rsf_cent_state_t s_d;

  // Tens digit even: ones 0/4/8; tens odd: ones 2/6
  function automatic logic isLeap(input logic [7:0] yr, input logic [1:0] cent);
    logic div4;
    div4 = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (yr == 8'h00) begin
      isLeap = (cent == 2'h0);
    end else begin
      isLeap = div4;
    end
  endfunction

  always_comb begin
    s_d = s_q;
    if (centIf.wrEn) begin
      s_d.century = centIf.wrData;
    end
    if (centIf.yearRoll) begin
      s_d.century = s_d.century + 2'h1;
    end
    s_d.leapYear = isLeap(centIf.yearBcd, s_d.century);
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_q <= rsf_pkg::CENT_RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign centIf.century  = s_q.century;
  assign centIf.leapYear = s_q.leapYear;

  AST_CENT_INC: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    (centIf.yearRoll && !centIf.wrEn) |=> (centIf.century == $past(centIf.century) + 2'h1))
    else $error("Century count did not step on year rollover");

  AST_LEAP_CENTURY: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    (centIf.yearBcd == 8'h00 && centIf.century != 2'h0 && !centIf.yearRoll && !centIf.wrEn)
    |=> !centIf.leapYear)
    else $error("Non-zero century year flagged as leap");

  AST_LEAP_DIV4: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
    (centIf.yearBcd == 8'h96) |=> centIf.leapYear)
    else $error("Year divisible by four not flagged as leap");

endmodule // rsf_century

// file: rsf_top.sv
`timescale 1ns/1ns
module rsf_top #(
  parameter longint unsigned CheckIntervalCycles = rsf_pkg::CHECK_INTERVAL_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          hsel,
  input  wire logic [rsf_pkg::AHB_ADDR_W-1:0] haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          oscStoppedIn,
  input  wire logic                          battLowIn,
  input  wire logic                          mainPowerGoodIn,
  input  wire logic                          alarmIrqReq,
  input  wire logic                          watchdogIrqReq,
  input  wire logic                          yearRollover,
  input  wire logic [7:0]                    yearBcd,
  input  wire logic                          irqPinI,
  output logic                               irqPinO,
  output logic                               irqPinOe,
  output logic                               irq,
  output logic                               stopBitOut,
  output logic                               frequencyTestOut,
  output logic                               squareWaveEnableOut,
  output logic                               haltUpdateOut,
  output logic                               countdownEnableOut,
  output logic      [1:0]                    centuryCount,
  output logic                               leapYear
);

  localparam logic [rsf_pkg::CHK_CNT_W-1:0] CHK_LAST =
    rsf_pkg::CHK_CNT_W'(CheckIntervalCycles - 64'd1);

  logic [1:0]          rstSync;
  logic                rstSyncN;
  rsf_pkg::rsf_state_t s_q;
  rsf_pkg::rsf_state_t s_d;
  logic                pwrRise;
  logic                checkNow;
  logic                ofSetNow;
  logic                irqActive;
  logic                wrStrobe;
  logic                flagsClr;
  logic [31:0]         readData;

  rsf_cent_if centIf ();

  rsf_century u_century (
    .clk_sys  (clk_sys),
    .rstSyncN (rstSyncN),
    .centIf   (centIf)
  );

  // Release only; assertion of the pin reset stays asynchronous
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  function automatic logic [31:0] readReg(input rsf_pkg::rsf_state_t s,
                                          input logic [1:0] cent,
                                          input logic leap);
    logic [31:0] r;
    r = 32'h0;
    case (s.busAddr)
      rsf_pkg::OFS_CTRL: begin
        r[rsf_pkg::B_STOP] = s.stopBit;
        r[rsf_pkg::B_FT]   = s.freqTest;
        r[rsf_pkg::B_SQUARE_WAVE_ENABLE] = s.sqwEnable;
        r[rsf_pkg::B_ABE]  = s.backupAlarmEn;
        r[rsf_pkg::B_OSC_FAIL_IRQ_ENABLE] = s.ofIrqEn;
        r[rsf_pkg::B_FIRST_ALARM_IRQ_ENABLE] = s.a1IrqEn;
        r[rsf_pkg::B_HT]   = s.haltUpdate;
        r[rsf_pkg::B_OUT]  = s.outLevel;
        r[rsf_pkg::B_PIN]  = s.pinLevel;
      end
      rsf_pkg::OFS_FLAGS: begin
        r[rsf_pkg::B_OF] = s.oscFailFlag;
        r[rsf_pkg::B_BL] = s.battLowFlag;
      end
      rsf_pkg::OFS_TRIM: begin
        r[rsf_pkg::B_DTV +: 6] = s.digitalTrimValue;
        r[rsf_pkg::B_DTS]      = s.digitalTrimSign;
        r[rsf_pkg::B_ATV +: 8] = s.analogTrimValue;
        r[rsf_pkg::B_ATS]      = s.analogTrimSign;
      end
      rsf_pkg::OFS_TIMER: begin
        r[rsf_pkg::B_TD +: 2]  = s.countdownSrcSel;
        r[rsf_pkg::B_TIE]      = s.countdownIrqEn;
        r[rsf_pkg::B_TP]       = s.countdownPulseMode;
        r[rsf_pkg::B_TE]       = s.countdownEnable;
        r[rsf_pkg::B_RS0]      = s.rateSelBit0;
        r[rsf_pkg::B_RSU +: 3] = s.rateSelUpper;
        r[rsf_pkg::B_OTP]      = s.otpBit;
        r[rsf_pkg::B_SECOND_ALARM_ENABLE]     = s.secondAlarmEnable;
      end
      rsf_pkg::OFS_WDOG: begin
        r[rsf_pkg::B_RB +: 2]  = s.watchdogRes;
        r[rsf_pkg::B_BMB +: 5] = s.watchdogMult;
      end
      rsf_pkg::OFS_RPT: begin
        r[rsf_pkg::B_RPT1 +: 5] = s.firstAlarmRepeat;
        r[rsf_pkg::B_RPT2 +: 5] = s.secondAlarmRepeat;
      end
      rsf_pkg::OFS_CENT: begin
        r[rsf_pkg::B_CB +: 2] = cent;
        r[rsf_pkg::B_LEAP]    = leap;
      end
      rsf_pkg::OFS_ISTAT: r[rsf_pkg::IRQ_W-1:0] = s.irqStatus;
      rsf_pkg::OFS_IMASK: r[rsf_pkg::IRQ_W-1:0] = s.irqMask;
      default: r = 32'h0;
    endcase
    readReg = r;
  endfunction

  always_comb begin
    s_d = s_q;
    // Three-stage synchronisers; a change counts once stages two and three agree
    s_d.oscSync  = {s_q.oscSync[1:0], oscStoppedIn};
    s_d.battSync = {s_q.battSync[1:0], battLowIn};
    s_d.pwrSync  = {s_q.pwrSync[1:0], mainPowerGoodIn};
    s_d.pinSync  = {s_q.pinSync[1:0], irqPinI};
    if (s_q.oscSync[2] == s_q.oscSync[1]) begin
      s_d.oscStopped = s_q.oscSync[2];
    end
    if (s_q.battSync[2] == s_q.battSync[1]) begin
      s_d.battLow = s_q.battSync[2];
    end
    if (s_q.pwrSync[2] == s_q.pwrSync[1]) begin
      s_d.pwrGood = s_q.pwrSync[2];
    end
    if (s_q.pinSync[2] == s_q.pinSync[1]) begin
      s_d.pinLevel = s_q.pinSync[2];
    end

    // Main power coming up is a power-up event, first or battery-backed
    pwrRise  = s_d.pwrGood & ~s_q.pwrGood;
    checkNow = pwrRise | (s_q.pwrGood & (s_q.checkCnt == CHK_LAST));
    if (!s_q.pwrGood || checkNow) begin
      s_d.checkCnt = '0;
    end else begin
      s_d.checkCnt = s_q.checkCnt + rsf_pkg::CHK_CNT_W'(1);
    end
    // Comparator is looked at only here, so noise between checks is ignored
    if (checkNow) begin
      s_d.battLowFlag = s_q.battLow;
    end

    // Bus data phase
    wrStrobe = s_q.busActive & s_q.busWrite;
    flagsClr = 1'b0;
    if (wrStrobe) begin
      case (s_q.busAddr)
        rsf_pkg::OFS_CTRL: begin
          s_d.stopBit       = hwdata[rsf_pkg::B_STOP];
          s_d.freqTest      = hwdata[rsf_pkg::B_FT];
          s_d.sqwEnable     = hwdata[rsf_pkg::B_SQUARE_WAVE_ENABLE];
          s_d.backupAlarmEn = hwdata[rsf_pkg::B_ABE];
          s_d.ofIrqEn       = hwdata[rsf_pkg::B_OSC_FAIL_IRQ_ENABLE];
          s_d.a1IrqEn       = hwdata[rsf_pkg::B_FIRST_ALARM_IRQ_ENABLE];
          s_d.haltUpdate    = hwdata[rsf_pkg::B_HT];
          s_d.outLevel      = hwdata[rsf_pkg::B_OUT];
        end
        rsf_pkg::OFS_FLAGS: begin
          // Only a zero clears; writing one leaves the flag alone
          flagsClr = ~hwdata[rsf_pkg::B_OF];
        end
        rsf_pkg::OFS_TRIM: begin
          s_d.digitalTrimValue = hwdata[rsf_pkg::B_DTV +: 6];
          s_d.digitalTrimSign  = hwdata[rsf_pkg::B_DTS];
          s_d.analogTrimValue  = hwdata[rsf_pkg::B_ATV +: 8];
          s_d.analogTrimSign   = hwdata[rsf_pkg::B_ATS];
        end
        rsf_pkg::OFS_TIMER: begin
          s_d.countdownSrcSel    = hwdata[rsf_pkg::B_TD +: 2];
          s_d.countdownIrqEn     = hwdata[rsf_pkg::B_TIE];
          s_d.countdownPulseMode = hwdata[rsf_pkg::B_TP];
          s_d.countdownEnable    = hwdata[rsf_pkg::B_TE];
          s_d.rateSelBit0        = hwdata[rsf_pkg::B_RS0];
          s_d.rateSelUpper       = hwdata[rsf_pkg::B_RSU +: 3];
          s_d.otpBit             = hwdata[rsf_pkg::B_OTP];
          s_d.secondAlarmEnable  = hwdata[rsf_pkg::B_SECOND_ALARM_ENABLE];
        end
        rsf_pkg::OFS_WDOG: begin
          s_d.watchdogRes  = hwdata[rsf_pkg::B_RB +: 2];
          s_d.watchdogMult = hwdata[rsf_pkg::B_BMB +: 5];
        end
        rsf_pkg::OFS_RPT: begin
          s_d.firstAlarmRepeat  = hwdata[rsf_pkg::B_RPT1 +: 5];
          s_d.secondAlarmRepeat = hwdata[rsf_pkg::B_RPT2 +: 5];
        end
        rsf_pkg::OFS_IMASK: s_d.irqMask = hwdata[rsf_pkg::IRQ_W-1:0];
        default: s_d.irqMask = s_d.irqMask;
      endcase
    end

    // Sampled whether or not main power is up, so stops in backup are kept
    ofSetNow = s_q.oscStopped | s_q.stopBit;
    if (flagsClr) begin
      s_d.oscFailFlag = 1'b0;
    end
    if (ofSetNow) begin
      s_d.oscFailFlag = 1'b1;
    end

    // Battery-backed power-up; at first power-up these match the defaults
    if (pwrRise) begin
      s_d.freqTest        = 1'b0;
      s_d.watchdogMult    = 5'h0;
      s_d.watchdogRes     = 2'h0;
      s_d.countdownEnable = 1'b0;
      s_d.haltUpdate      = 1'b1;
    end

    // Sticky events, write one to clear; a new event beats the clear
    s_d.irqStatus = s_q.irqStatus;
    if (wrStrobe && s_q.busAddr == rsf_pkg::OFS_ISTAT) begin
      s_d.irqStatus = s_q.irqStatus & ~hwdata[rsf_pkg::IRQ_W-1:0];
    end
    s_d.irqStatus[rsf_pkg::I_OF]   = s_d.irqStatus[rsf_pkg::I_OF] | (ofSetNow & ~s_q.oscFailFlag);
    s_d.irqStatus[rsf_pkg::I_BL]   = s_d.irqStatus[rsf_pkg::I_BL] |
                                     (checkNow & s_q.battLow & ~s_q.battLowFlag);
    s_d.irqStatus[rsf_pkg::I_CENT] = s_d.irqStatus[rsf_pkg::I_CENT] | yearRollover;
    s_d.irqOut = |(s_q.irqStatus & s_q.irqMask);

    // Oscillator-fail, first-alarm or watchdog interrupt wins; only an idle pin follows the level bit
    irqActive = (s_q.ofIrqEn & s_q.oscFailFlag) | (s_q.a1IrqEn & alarmIrqReq) | watchdogIrqReq;
    s_d.irqPinOe = irqActive | ~s_q.outLevel;

    // Address phase; only whole-word transfers are taken
    s_d.busActive = hsel & htrans[1] & hready & (hsize == rsf_pkg::HSIZE_WORD);
    s_d.busWrite  = hwrite;
    s_d.busAddr   = haddr;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_q <= rsf_pkg::RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign centIf.yearRoll = yearRollover;
  assign centIf.yearBcd  = yearBcd;
  assign centIf.wrEn     = wrStrobe && (s_q.busAddr == rsf_pkg::OFS_CENT);
  assign centIf.wrData   = hwdata[rsf_pkg::B_CB +: 2];

  // Read mux sits on flops and the latched address, so no extra wait state
  assign readData  = readReg(s_q, centIf.century, centIf.leapYear);
  assign hrdata    = (s_q.busActive && !s_q.busWrite) ? readData : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign irqPinO             = 1'b0;
  assign irqPinOe            = s_q.irqPinOe;
  assign irq                 = s_q.irqOut;
  assign stopBitOut          = s_q.stopBit;
  assign frequencyTestOut    = s_q.freqTest;
  assign squareWaveEnableOut = s_q.sqwEnable;
  assign haltUpdateOut       = s_q.haltUpdate;
  assign countdownEnableOut  = s_q.countdownEnable;
  assign centuryCount        = centIf.century;
  assign leapYear            = centIf.leapYear;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstSyncN);

  AST_CHECK_DAILY: assert property (
    (s_q.pwrGood && s_d.pwrGood && s_q.checkCnt == CHK_LAST) |=> (s_q.battLowFlag == $past(s_q.battLow)))
    else $error("Daily battery check did not sample the comparator");

  AST_BL_SET: assert property (
    (pwrRise && s_q.battLow) |=> s_q.battLowFlag)
    else $error("Battery-low flag not set by failing power-up check");

  AST_BL_HOLD: assert property (
    !checkNow |=> $stable(s_q.battLowFlag))
    else $error("Battery-low flag changed between checks");

  AST_NO_CHECK_BATT: assert property (
    (!s_q.pwrGood ##1 !s_q.pwrGood) |-> ($stable(s_q.battLowFlag) && s_q.checkCnt == '0))
    else $error("Battery check ran without main power");

  AST_PIN_FOLLOW: assert property (
    !irqActive |=> (irqPinOe == !$past(s_q.outLevel)))
    else $error("Idle pin does not follow the output-level bit");

  AST_OF_SET: assert property (
    (s_q.oscStopped || s_q.stopBit) |=> s_q.oscFailFlag)
    else $error("Oscillator stop did not set the fail flag");

  AST_OF_HOLD: assert property (
    (s_q.oscFailFlag && !flagsClr) |=> s_q.oscFailFlag)
    else $error("Oscillator fail flag dropped without a software clear");

  AST_OF_IRQ: assert property (
    (s_q.ofIrqEn && s_q.oscFailFlag) |=> (irqPinOe && irqPinO == 1'b0))
    else $error("Oscillator fail interrupt not driven on the pin");

  AST_PWRUP: assert property (
    pwrRise |=> (!s_q.freqTest && s_q.haltUpdate && !s_q.countdownEnable &&
                 s_q.watchdogMult == 5'h0 && s_q.watchdogRes == 2'h0))
    else $error("Battery-backed power-up defaults not applied");

endmodule // rsf_top

// file: rsf_host_model.sv
`timescale 1ns/1ns
module rsf_host_model (
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        irqPinOe,
  output logic             irqPinI,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Pull-up holds the pin high unless the device sinks it
  assign irqPinI = irqPinOe ? 1'b0 : 1'b1;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= rsf_pkg::HSIZE_WORD;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    // Data-phase word still stands at the edge that ends it
    q = hrdata;
    // Released data bus must not keep showing the last word
    hwdata <= ~d;
  endtask
endmodule // rsf_host_model

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam longint unsigned Ivl = 100;
  logic clk_sys = 1'b0, resetn = 1'b0, oscStoppedIn = 1'b0, battLowIn = 1'b0, mainPowerGoodIn = 1'b1;
  logic watchdogIrqReq = 1'b0, yearRollover = 1'b0, alarmIrqReq = 1'b0;
  logic [7:0] yearBcd = 8'h00;
  logic hsel, hwrite, hready, hreadyout, hresp, irqPinI, irqPinO, irqPinOe, irq, leapYear;
  logic stopBitOut, frequencyTestOut, squareWaveEnableOut, haltUpdateOut, countdownEnableOut;
  logic [1:0] htrans, centuryCount;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] ra[8] = '{rsf_pkg::OFS_CTRL, rsf_pkg::OFS_FLAGS, rsf_pkg::OFS_TRIM, rsf_pkg::OFS_TIMER,
    rsf_pkg::OFS_WDOG, rsf_pkg::OFS_RPT, rsf_pkg::OFS_CENT, 8'h40};
  logic [31:0] re[8] = '{32'h1c4, 32'h4, 32'h0, 32'h103, 32'h0, 32'h0, 32'h4, 32'h0};

  rsf_top #(.CheckIntervalCycles(Ivl)) u_rsf_top (
    .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .oscStoppedIn, .battLowIn, .mainPowerGoodIn, .alarmIrqReq, .watchdogIrqReq,
    .yearRollover, .yearBcd, .irqPinI, .irqPinO, .irqPinOe, .irq, .stopBitOut, .frequencyTestOut,
    .squareWaveEnableOut, .haltUpdateOut, .countdownEnableOut, .centuryCount, .leapYear);
  rsf_host_model u_rsf_host_model (.clk_sys, .hready, .hrdata, .irqPinOe, .irqPinI, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);

  assign hready = hreadyout;
  always #4 clk_sys = ~clk_sys;

  function automatic logic isLeap(int y, int c);
    return (y % 4 == 0) && (y != 0 || c == 0);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_rsf_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_rsf_host_model.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: whole sequence needs about 670 cycles
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] r, t;
    int c, y;
    void'($urandom(32'h6a65d5bc));
    cyc(5);
    resetn <= 1'b1;
    cyc(14);
    chk("outs", {stopBitOut, frequencyTestOut, squareWaveEnableOut, haltUpdateOut, countdownEnableOut,
      centuryCount, hresp}, 32'h30);
    foreach (ra[i]) rc(ra[i], re[i]);
    // Scaled run: oscillator counts as settled long before this clear
    wr(rsf_pkg::OFS_FLAGS, 32'h0);
    rc(rsf_pkg::OFS_FLAGS, 32'h0);
    wr(rsf_pkg::OFS_CTRL, 32'h0d4);
    // Filter wants two agreeing samples; this three-cycle pulse passes it and sets the flag
    oscStoppedIn <= 1'b1;
    cyc(3);
    oscStoppedIn <= 1'b0;
    cyc(10);
    rc(rsf_pkg::OFS_FLAGS, 32'h4);
    chk("pinOe", irqPinOe, 1);
    wr(rsf_pkg::OFS_FLAGS, 32'h0);
    cyc(3);
    chk("pinOe", irqPinOe, 0);
    wr(rsf_pkg::OFS_CTRL, 32'h0d5);
    wr(rsf_pkg::OFS_CTRL, 32'h0d4);
    cyc(4);
    rc(rsf_pkg::OFS_FLAGS, 32'h4);
    wr(rsf_pkg::OFS_CTRL, 32'h044);
    cyc(4);
    chk("pin", {irqPinO, irqPinOe}, 1);
    rc(rsf_pkg::OFS_CTRL, 32'h044);
    wr(rsf_pkg::OFS_CTRL, 32'h0e4);
    watchdogIrqReq <= 1'b1;
    cyc(4);
    chk("pinOe", irqPinOe, 1);
    watchdogIrqReq <= 1'b0;
    alarmIrqReq <= 1'b1;
    cyc(4);
    chk("pinOe", irqPinOe, 1);
    alarmIrqReq <= 1'b0;
    wr(rsf_pkg::OFS_FLAGS, 32'h0);
    cyc(4);
    chk("pinOe", irqPinOe, 0);
    wr(rsf_pkg::OFS_ISTAT, 32'h7);
    wr(rsf_pkg::OFS_IMASK, 32'h0);
    battLowIn <= 1'b1;
    cyc(Ivl + 20);
    rc(rsf_pkg::OFS_FLAGS, 32'h10);
    chk("irq", irq, 0);
    rc(rsf_pkg::OFS_ISTAT, 32'h2);
    wr(rsf_pkg::OFS_IMASK, 32'h2);
    cyc(3);
    chk("irq", irq, 1);
    wr(rsf_pkg::OFS_ISTAT, 32'h2);
    cyc(3);
    chk("irq", irq, 0);
    r = $urandom & 32'h1ff7f;
    t = ($urandom & 32'h2fe3) | 32'h80;
    wr(rsf_pkg::OFS_TRIM, r);
    wr(rsf_pkg::OFS_TIMER, t);
    wr(rsf_pkg::OFS_WDOG, $urandom & 32'h7f);
    wr(rsf_pkg::OFS_CTRL, 32'h08e);
    mainPowerGoodIn <= 1'b0;
    battLowIn <= 1'b0;
    cyc(10);
    oscStoppedIn <= 1'b1;
    cyc(3);
    oscStoppedIn <= 1'b0;
    cyc(3 * Ivl);
    rc(rsf_pkg::OFS_FLAGS, 32'h14);
    mainPowerGoodIn <= 1'b1;
    cyc(20);
    rc(rsf_pkg::OFS_FLAGS, 32'h4);
    rc(rsf_pkg::OFS_CTRL, 32'h1cc);
    rc(rsf_pkg::OFS_TIMER, t & ~32'h80);
    rc(rsf_pkg::OFS_WDOG, 32'h0);
    rc(rsf_pkg::OFS_TRIM, r);
    wr(rsf_pkg::OFS_CENT, 32'h3);
    rc(rsf_pkg::OFS_CENT, 32'h3);
    c = 3;
    for (int i = 0; i < 6; i++) begin
      yearRollover <= 1'b1;
      cyc(1);
      yearRollover <= 1'b0;
      c = (c + 1) % 4;
      cyc(3);
      chk("century", centuryCount, c);
      y = (i % 3 == 0) ? 0 : (i == 4) ? 96 : $urandom % 100;
      yearBcd <= 8'((y / 10) * 16 + y % 10);
      cyc(3);
      chk("leap", leapYear, isLeap(y, c));
    end
    complete_run();
  end
endmodule // testbench
